// ---- fieldbus_cyclic_data_channel.sv ----
// cyclic process data channel of a drive on a fieldbus, with register file
// assumes telegram framing and bus rate detection done by the bus phy logic

`timescale 1ns/10ps

// What this block does
// - command channel length 0..32 bytes in word steps, reset value 2
// - lengths count process data only; parameter channel sized on its own
// - actual channel length 0..32 bytes in word steps, reset value 2
// - format 0 sends low half of 32-bit values first, 1 high half; reset 0
// - supervision timeout in ms taken from the parameter telegram, reset 0
// - silence longer than the timeout raises a communication error
// - data processed every 500..65000 us, reset 2000 us
// - in profile fffe control bits have fixed meanings set by the profile
// - in profile fffe a fixed-layout status word reports the drive state
// - token buses show the detected rate; can buses use the set rate
// - a set can rate of 0 turns on automatic rate detection
// - a list chooses the contents of the actual value channel
// - a list chooses the contents of the command value channel
// - optional parameter channel of 0..16 bytes beside the process data
// - profile, reset ff82, picks word handling and fixes layout unless free
// - bus state machine state readable as text
// - profile ff82 uses a 16-bit control word from the bus
module fieldbus_cyclic_data_channel
	import fieldbus_cyclic_pkg::*;
(
	input  wire logic              i_clock,
	input  wire logic              i_sys_rst,
	input  wire logic [7:0]        i_axi_awaddr,
	input  wire logic              i_axi_awvalid,
	output logic                   o_axi_awready,
	input  wire logic [31:0]       i_axi_wdata,
	input  wire logic [3:0]        i_axi_wstrb,
	input  wire logic              i_axi_wvalid,
	output logic                   o_axi_wready,
	output logic [1:0]             o_axi_bresp,
	output logic                   o_axi_bvalid,
	input  wire logic              i_axi_bready,
	input  wire logic [7:0]        i_axi_araddr,
	input  wire logic              i_axi_arvalid,
	output logic                   o_axi_arready,
	output logic [31:0]            o_axi_rdata,
	output logic [1:0]             o_axi_rresp,
	output logic                   o_axi_rvalid,
	input  wire logic              i_axi_rready,
	output logic                   o_irq,
	input  wire logic              i_bus_online,
	input  wire logic              i_bus_is_can,
	input  wire logic              i_ring_bus,
	input  wire logic [15:0]       i_detected_kbaud,
	input  wire logic              i_prm_valid,
	input  wire logic [15:0]       i_prm_watchdog_ms,
	input  wire logic              i_cfg_valid,
	input  wire logic              i_cmd_valid,
	input  wire telegram_type      i_cmd,
	input  wire telegram_type      i_act_src,
	input  wire drive_status_type  i_drive,
	output telegram_type           o_cmd,
	output telegram_type           o_act,
	output logic                   o_act_valid,
	output logic [15:0]            o_control_word,
	output logic                   o_drive_enable,
	output logic                   o_drive_halt,
	output logic                   o_comm_error,
	output logic                   o_autobaud_en,
	output logic [15:0]            o_baud_kbaud,
	output bus_state_type          o_bus_state
);

	// ************************
	// reset image
	// ************************
	localparam state_type RESET_STATE = '{
		aw_rdy:   1'b1,
		w_rdy:    1'b1,
		ar_rdy:   1'b1,
		cmd_len:  LEN_DEF,
		act_len:  LEN_DEF,
		prm_len:  PRM_DEF,
		fmt:      FMT_DEF,
		wd_ms:    WD_DEF,
		cycle_us: CYC_DEF,
		profile:  PROF_DEF,
		baud_cfg: BAUD_AUTO,
		bus_st:   ST_OFFLINE,
		default:  '0
	};

	state_type q;
	state_type n;

	logic                free_prof;
	logic [NW-1:0][15:0] rx_ord;
	logic [NW-1:0][15:0] cmd_gather;
	logic [NW-1:0][15:0] act_pre;
	logic [NW-1:0][15:0] act_gather;
	logic [PW-1:0][15:0] prm_rx_mask;
	logic [PW-1:0][15:0] prm_tx_mask;

	assign free_prof = (q.profile == PROF_FREE);

	// ************************
	// helpers
	// ************************

	// clamp to an even byte count
	function automatic logic [5:0] even_len(input logic [31:0] v);
		if (v > 32'(LEN_MAX))
			return LEN_MAX;
		return {v[5:1], 1'b0};
	endfunction

	// parameter channel length clamp
	function automatic logic [4:0] prm_len(input logic [31:0] v);
		if (v > 32'(PRM_MAX))
			return PRM_MAX;
		return {v[4:1], 1'b0};
	endfunction

	// state name text
	function automatic logic [31:0] bus_text(input bus_state_type s);
		logic [31:0] t;
		t = TXT_OFFL;
		unique case (s)
			ST_OFFLINE:   t = TXT_OFFL;
			ST_WAIT_PRM:  t = TXT_WPRM;
			ST_WAIT_CFG:  t = TXT_WCFG;
			ST_DATA_EXCH: t = TXT_DXCH;
		endcase
		return t;
	endfunction

	// register read mux, response code on top
	function automatic logic [33:0] reg_read(input logic [7:0] a, input state_type s);
		logic [31:0] d;
		logic [1:0]  r;
		d = '0;
		r = RESP_OKAY;
		case ({a[7:2], 2'b00})
			A_CMD_LEN:  d = 32'(s.cmd_len);
			A_ACT_LEN:  d = 32'(s.act_len);
			A_PRM_LEN:  d = 32'(s.prm_len);
			A_FORMAT:   d = 32'(s.fmt);
			A_WATCHDOG: d = 32'(s.wd_ms);
			A_CYCLE:    d = 32'(s.cycle_us);
			A_PROFILE:  d = 32'(s.profile);
			A_BAUD:     d = 32'(s.baud_eff);
			A_MAP_IDX:  d = 32'(s.map_idx);
			A_ACT_MAP:  d = 32'(s.act_map[s.map_idx]);
			A_CMD_MAP:  d = 32'(s.cmd_map[s.map_idx]);
			A_IRQ_STS:  d = 32'(s.irq_sts);
			A_IRQ_MASK: d = 32'(s.irq_mask);
			A_BUS_TEXT: d = bus_text(s.bus_st);
			A_CTRL_WD:  d = 32'(s.control_word);
			A_STS_WD:   d = 32'(s.sts_word);
			default:    r = RESP_SLVERR;
		endcase
		return {r, d};
	endfunction

	// ************************
	// channel mapping, one slice per telegram word
	// ************************
	genvar k;
	generate
		for (k = 0; k < NW; k++) begin : g_word
			localparam logic [5:0] KB = 6'(2 * k);
			logic [3:0] csel;
			logic [3:0] asel;

			// 32-bit halves swap in pairs when high half goes first
			assign rx_ord[k] = q.fmt ? i_cmd.data[k ^ 1] : i_cmd.data[k];

			// command image slot k picks a telegram word from the list
			assign csel = free_prof ? q.cmd_map[k] : 4'(k);
			assign cmd_gather[k] = ({1'b0, csel, 1'b0} < q.cmd_len) ?
				rx_ord[csel] : 16'h0000;

			// actual telegram word k picks a source word from the list, except word 0 in the free profile, which takes the status word
			assign asel = free_prof ? q.act_map[k] : 4'(k);
			assign act_pre[k] = (free_prof && k == 0) ?
				q.sts_word : i_act_src.data[asel];
			assign act_gather[k] = (KB < q.act_len) ?
				(q.fmt ? act_pre[k ^ 1] : act_pre[k]) : 16'h0000;
		end

		for (k = 0; k < PW; k++) begin : g_param
			localparam logic [4:0] PB = 5'(2 * k);
			// parameter channel masked by its own length
			assign prm_rx_mask[k] = (PB < q.prm_len) ? i_cmd.param[k] : 16'h0000;
			assign prm_tx_mask[k] = (PB < q.prm_len) ? i_act_src.param[k] : 16'h0000;
		end
	endgenerate

	// ************************
	// next state
	// ************************
	always_comb begin
		logic [33:0]      rv;
		logic [31:0]      m;
		logic [31:0]      wv;
		logic [IRQ_W-1:0] clr;
		logic [IRQ_W-1:0] ev;
		logic             us_tick;
		logic             ms_tick;
		logic             cyc_tick;
		logic             wd_err;
		rv       = '0;
		m        = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
		wv       = '0;
		clr      = '0;
		ev       = '0;
		us_tick  = 1'b0;
		ms_tick  = 1'b0;
		cyc_tick = 1'b0;
		wd_err   = 1'b0;
		n        = q;
		n.act_valid = 1'b0;

		// bus handshakes and answer release
		if (q.aw_rdy && i_axi_awvalid) begin
			n.aw_held = 1'b1;
			n.awaddr  = i_axi_awaddr;
		end
		if (q.w_rdy && i_axi_wvalid) begin
			n.w_held = 1'b1;
			n.wdata  = i_axi_wdata;
			n.wstrb  = i_axi_wstrb;
		end
		if (q.bvalid && i_axi_bready)
			n.bvalid = 1'b0;
		if (q.rvalid && i_axi_rready)
			n.rvalid = 1'b0;
		if (q.ar_rdy && i_axi_arvalid) begin
			rv      = reg_read(i_axi_araddr, q);
			n.rvalid = 1'b1;
			n.rdata  = rv[31:0];
			n.rresp  = rv[33:32];
		end

		// register write once address and data are both in
		if (q.aw_held && q.w_held) begin
			rv        = reg_read(q.awaddr, q);
			wv        = (rv[31:0] & ~m) | (q.wdata & m);
			n.aw_held = 1'b0;
			n.w_held  = 1'b0;
			n.bvalid  = 1'b1;
			n.bresp   = rv[33:32];
			case ({q.awaddr[7:2], 2'b00})
				A_CMD_LEN:  n.cmd_len = even_len(wv);
				A_ACT_LEN:  n.act_len = even_len(wv);
				A_PRM_LEN:  n.prm_len = prm_len(wv);
				A_FORMAT:   n.fmt = wv[0];
				A_CYCLE: begin
					if (wv[15:0] < CYC_MIN)
						n.cycle_us = CYC_MIN;
					else if (wv[15:0] > CYC_MAX)
						n.cycle_us = CYC_MAX;
					else
						n.cycle_us = wv[15:0];
				end
				A_PROFILE:  n.profile = wv[15:0];
				A_BAUD: begin
					n.baud_cfg = (q.baud_cfg & ~m[15:0]) | (q.wdata[15:0] & m[15:0]);
				end
				A_MAP_IDX:  n.map_idx = wv[3:0];
				A_ACT_MAP:  n.act_map[q.map_idx] = wv[3:0];
				A_CMD_MAP:  n.cmd_map[q.map_idx] = wv[3:0];
				A_IRQ_STS:  clr = q.wdata[IRQ_W-1:0] & m[IRQ_W-1:0];
				A_IRQ_MASK: n.irq_mask = wv[IRQ_W-1:0];
				default: begin
				end
			endcase
		end

		// microsecond, millisecond and process cycle ticks
		us_tick = (q.us_div == 7'(CYC_PER_US - 1));
		n.us_div = us_tick ? 7'h00 : q.us_div + 7'h01;
		if (us_tick) begin
			ms_tick  = (q.ms_div == 10'(US_PER_MS - 1));
			n.ms_div = ms_tick ? 10'h000 : q.ms_div + 10'h001;
			cyc_tick = (q.cyc_cnt >= q.cycle_us - 16'h0001);
			n.cyc_cnt = cyc_tick ? 16'h0000 : q.cyc_cnt + 16'h0001;
		end

		// supervision of the master, silent while timeout is 0
		if (i_cmd_valid || q.bus_st != ST_DATA_EXCH)
			n.wd_cnt = '0;
		else if (ms_tick && !(&q.wd_cnt))
			n.wd_cnt = q.wd_cnt + 17'h00001;
		wd_err = (q.wd_ms != 16'h0000) &&
			(q.wd_cnt > {1'b0, q.wd_ms});

		// bus protocol state machine
		unique case (q.bus_st)
			ST_OFFLINE: begin
				if (i_bus_online)
					n.bus_st = ST_WAIT_PRM;
			end
			ST_WAIT_PRM: begin
			end
			ST_WAIT_CFG: begin
				if (i_cfg_valid)
					n.bus_st = ST_DATA_EXCH;
			end
			ST_DATA_EXCH: begin
				if (wd_err) begin
					n.bus_st     = ST_WAIT_PRM;
					n.comm_error = 1'b1;
					ev[IRQ_COMM] = 1'b1;
				end
			end
		endcase
		if (i_prm_valid && q.bus_st != ST_OFFLINE) begin
			n.wd_ms      = i_prm_watchdog_ms;
			n.comm_error = 1'b0;
			n.bus_st     = ST_WAIT_CFG;
		end
		if (!i_bus_online)
			n.bus_st = ST_OFFLINE;

		// command telegram held until the next process cycle
		if (i_cmd_valid && q.bus_st == ST_DATA_EXCH) begin
			n.pend.data  = cmd_gather;
			n.pend.param = prm_rx_mask;
			n.ctrl_pend  = i_cmd.data[0];
			ev[IRQ_RX]   = 1'b1;
		end

		// cyclic processing of command and actual values
		if (cyc_tick && q.bus_st == ST_DATA_EXCH) begin
			n.cmd_out        = q.pend;
			n.control_word   = q.ctrl_pend;
			n.act_out.data   = act_gather;
			n.act_out.param  = prm_tx_mask;
			n.act_valid      = 1'b1;
			ev[IRQ_TICK]     = 1'b1;
			if (free_prof) begin
				n.drive_enable = q.ctrl_pend[FREE_EN];
				n.drive_halt   = q.ctrl_pend[FREE_HALT];
			end else begin
				n.drive_enable = q.ctrl_pend[IO_EN];
				n.drive_halt   = q.ctrl_pend[IO_HALT];
			end
		end

		// fixed-layout status word
		n.sts_word = {10'h000, q.bus_st, q.comm_error,
			i_drive.fault, i_drive.enabled, i_drive.ready};

		// ring bus length mismatch check
		ev[IRQ_RING] = i_ring_bus && (q.cmd_len != q.act_len);

		// bus rate: detected on token buses, set or auto on can
		if (i_bus_is_can && q.baud_cfg != BAUD_AUTO) begin
			n.baud_eff    = q.baud_cfg;
			n.autobaud_en = 1'b0;
		end else begin
			n.baud_eff    = i_detected_kbaud;
			n.autobaud_en = 1'b1;
		end

		// sticky events, set wins over a clear in the same cycle
		n.irq_sts = (q.irq_sts & ~clr) | ev;
		n.irq     = |(n.irq_sts & n.irq_mask);

		// ready for the next beat only while nothing is pending
		n.aw_rdy = !n.aw_held && !n.bvalid;
		n.w_rdy  = !n.w_held && !n.bvalid;
		n.ar_rdy = !n.rvalid;
	end

	// ************************
	// state register
	// ************************
	always_ff @(posedge i_clock) begin
		if (i_sys_rst)
			q <= RESET_STATE;
		else
			q <= n;
	end

	// outputs straight from the state register
	assign o_axi_awready  = q.aw_rdy;
	assign o_axi_wready   = q.w_rdy;
	assign o_axi_bvalid   = q.bvalid;
	assign o_axi_bresp    = q.bresp;
	assign o_axi_arready  = q.ar_rdy;
	assign o_axi_rvalid   = q.rvalid;
	assign o_axi_rdata    = q.rdata;
	assign o_axi_rresp    = q.rresp;
	assign o_irq          = q.irq;
	assign o_cmd          = q.cmd_out;
	assign o_act          = q.act_out;
	assign o_act_valid    = q.act_valid;
	assign o_control_word = q.control_word;
	assign o_drive_enable = q.drive_enable;
	assign o_drive_halt   = q.drive_halt;
	assign o_comm_error   = q.comm_error;
	assign o_autobaud_en  = q.autobaud_en;
	assign o_baud_kbaud   = q.baud_eff;
	assign o_bus_state    = q.bus_st;

endmodule

// ---- fieldbus_cyclic_pkg.sv ----
// shared constants, register map and carrier types of the cyclic data channel
// assumes a 125 MHz system clock and an AXI4-Lite register master

package fieldbus_cyclic_pkg;

	// ************************
	// timing
	// ************************
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned US_NS         = 1000;
	localparam int unsigned CYC_PER_US    = US_NS / CLK_PERIOD_NS;
	localparam int unsigned US_PER_MS     = 1000;

	// ************************
	// limits and reset values
	// ************************
	localparam logic [5:0]  LEN_MAX   = 6'h20;
	localparam logic [5:0]  LEN_DEF   = 6'h02;
	localparam logic [4:0]  PRM_MAX   = 5'h10;
	localparam logic [4:0]  PRM_DEF   = 5'h00;
	localparam logic [15:0] CYC_MIN   = 16'h01f4;
	localparam logic [15:0] CYC_MAX   = 16'hfde8;
	localparam logic [15:0] CYC_DEF   = 16'h07d0;
	localparam logic [15:0] PROF_DEF  = 16'hff82;
	localparam logic [15:0] PROF_FREE = 16'hfffe;
	localparam logic [15:0] WD_DEF    = 16'h0000;
	localparam logic        FMT_DEF   = 1'b0;
	localparam logic [15:0] BAUD_AUTO = 16'h0000;
	localparam int unsigned NW        = 16;
	localparam int unsigned PW        = 8;

	// ************************
	// register byte addresses
	// ************************
	localparam logic [7:0] A_CMD_LEN  = 8'h00;
	localparam logic [7:0] A_ACT_LEN  = 8'h04;
	localparam logic [7:0] A_PRM_LEN  = 8'h08;
	localparam logic [7:0] A_FORMAT   = 8'h0c;
	localparam logic [7:0] A_WATCHDOG = 8'h10;
	localparam logic [7:0] A_CYCLE    = 8'h14;
	localparam logic [7:0] A_PROFILE  = 8'h18;
	localparam logic [7:0] A_BAUD     = 8'h1c;
	localparam logic [7:0] A_MAP_IDX  = 8'h20;
	localparam logic [7:0] A_ACT_MAP  = 8'h24;
	localparam logic [7:0] A_CMD_MAP  = 8'h28;
	localparam logic [7:0] A_IRQ_STS  = 8'h2c;
	localparam logic [7:0] A_IRQ_MASK = 8'h30;
	localparam logic [7:0] A_BUS_TEXT = 8'h34;
	localparam logic [7:0] A_CTRL_WD  = 8'h38;
	localparam logic [7:0] A_STS_WD   = 8'h3c;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ************************
	// field positions
	// ************************
	localparam int unsigned IRQ_COMM  = 0;
	localparam int unsigned IRQ_RX    = 1;
	localparam int unsigned IRQ_RING  = 2;
	localparam int unsigned IRQ_TICK  = 3;
	localparam int unsigned IRQ_W     = 4;
	localparam int unsigned FREE_EN   = 15;
	localparam int unsigned FREE_HALT = 13;
	localparam int unsigned IO_EN     = 0;
	localparam int unsigned IO_HALT   = 1;

	// state names as four ascii characters
	localparam logic [31:0] TXT_OFFL = 32'h4f46464c;
	localparam logic [31:0] TXT_WPRM = 32'h5750524d;
	localparam logic [31:0] TXT_WCFG = 32'h57434647;
	localparam logic [31:0] TXT_DXCH = 32'h44584348;

	// ************************
	// types
	// ************************
	typedef enum logic [1:0] {
		ST_OFFLINE   = 2'b00,
		ST_WAIT_PRM  = 2'b01,
		ST_WAIT_CFG  = 2'b10,
		ST_DATA_EXCH = 2'b11
	} bus_state_type;

	typedef struct packed {
		logic [NW-1:0][15:0] data;
		logic [PW-1:0][15:0] param;
	} telegram_type;

	typedef struct packed {
		logic ready;
		logic enabled;
		logic fault;
	} drive_status_type;

	typedef struct packed {
		logic                aw_rdy;
		logic                w_rdy;
		logic                ar_rdy;
		logic                aw_held;
		logic                w_held;
		logic [7:0]          awaddr;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [1:0]          rresp;
		logic [31:0]         rdata;
		logic [5:0]          cmd_len;
		logic [5:0]          act_len;
		logic [4:0]          prm_len;
		logic                fmt;
		logic [15:0]         wd_ms;
		logic [15:0]         cycle_us;
		logic [15:0]         profile;
		logic [15:0]         baud_cfg;
		logic [15:0]         baud_eff;
		logic [3:0]          map_idx;
		logic [NW-1:0][3:0]  act_map;
		logic [NW-1:0][3:0]  cmd_map;
		logic [IRQ_W-1:0]    irq_sts;
		logic [IRQ_W-1:0]    irq_mask;
		logic                irq;
		bus_state_type       bus_st;
		logic [6:0]          us_div;
		logic [9:0]          ms_div;
		logic [15:0]         cyc_cnt;
		logic [16:0]         wd_cnt;
		telegram_type        pend;
		logic [15:0]         ctrl_pend;
		telegram_type        cmd_out;
		telegram_type        act_out;
		logic                act_valid;
		logic [15:0]         control_word;
		logic [15:0]         sts_word;
		logic                drive_enable;
		logic                drive_halt;
		logic                comm_error;
		logic                autobaud_en;
	} state_type;

endpackage

// ---- fieldbus_cyclic_asserts.sv ----
// port assertions for the cyclic data channel
// assumes one clock domain and a synchronous active high reset
`timescale 1ns/10ps
module fieldbus_cyclic_asserts
	import fieldbus_cyclic_pkg::*;
(
	input  wire logic          i_clock,
	input  wire logic          i_sys_rst,
	input  wire logic          i_bus_online,
	input  wire logic          i_bus_is_can,
	input  wire logic [15:0]   i_detected_kbaud,
	input  wire logic          i_prm_valid,
	input  wire logic          i_cfg_valid,
	input  wire telegram_type  o_cmd,
	input  wire telegram_type  o_act,
	input  wire logic          o_act_valid,
	input  wire logic [15:0]   o_control_word,
	input  wire logic          o_comm_error,
	input  wire logic          o_autobaud_en,
	input  wire logic [15:0]   o_baud_kbaud,
	input  wire bus_state_type o_bus_state
);
	// ****************************************************************
	// port relations
	// ****************************************************************
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	AST_ACT_PULSE: assert property (o_act_valid |=> !o_act_valid)
		else $error("act valid held too long");
	AST_ACT_DXCH: assert property (o_act_valid |-> $past(o_bus_state) == ST_DATA_EXCH)
		else $error("tick outside data exchange");
	AST_HOLD: assert property ($changed(o_cmd) || $changed(o_act)
		|| $changed(o_control_word) |-> o_act_valid)
		else $error("images changed between ticks");
	AST_OFFLINE: assert property (!i_bus_online |=> o_bus_state == ST_OFFLINE)
		else $error("offline not forced");
	AST_PRM: assert property (i_prm_valid && i_bus_online && o_bus_state != ST_OFFLINE
		|=> o_bus_state == ST_WAIT_CFG && !o_comm_error)
		else $error("parameter telegram not taken");
	AST_CFG: assert property (i_cfg_valid && i_bus_online && !i_prm_valid
		&& o_bus_state == ST_WAIT_CFG |=> o_bus_state == ST_DATA_EXCH)
		else $error("config telegram not taken");
	AST_COMM: assert property ($rose(o_comm_error)
		|-> o_bus_state == ST_WAIT_PRM && $past(o_bus_state) == ST_DATA_EXCH)
		else $error("comm error without supervision loss");
	AST_BAUD: assert property (!i_bus_is_can [*2]
		|-> o_autobaud_en && o_baud_kbaud == $past(i_detected_kbaud))
		else $error("token bus rate not detected");

	cover property (o_act_valid && o_bus_state == ST_DATA_EXCH);
	cover property ($rose(o_bus_state == ST_DATA_EXCH));
	cover property (i_bus_is_can && !o_autobaud_en);
endmodule

bind fieldbus_cyclic_data_channel fieldbus_cyclic_asserts u_fieldbus_cyclic_asserts (
	.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_bus_online(i_bus_online),
	.i_bus_is_can(i_bus_is_can), .i_detected_kbaud(i_detected_kbaud),
	.i_prm_valid(i_prm_valid), .i_cfg_valid(i_cfg_valid), .o_cmd(o_cmd), .o_act(o_act),
	.o_act_valid(o_act_valid), .o_control_word(o_control_word),
	.o_comm_error(o_comm_error), .o_autobaud_en(o_autobaud_en),
	.o_baud_kbaud(o_baud_kbaud), .o_bus_state(o_bus_state)
);

// ---- fieldbus_master_model.sv ----
// fieldbus master model sending link telegrams to the drive
// assumes the bench calls its tasks from one process
`timescale 1ns/10ps
module fieldbus_master_model
	import fieldbus_cyclic_pkg::*;
(
	input  wire logic   i_clock,
	output logic        o_online,
	output logic        o_is_can,
	output logic        o_ring,
	output logic [15:0] o_kbaud,
	output logic        o_prm_valid,
	output logic [15:0] o_prm_wd,
	output logic        o_cfg_valid,
	output logic        o_cmd_valid,
	output telegram_type o_cmd
);
	// ****************************************************************
	// link tasks
	// ****************************************************************
	initial begin
		{o_online, o_is_can, o_ring, o_kbaud} = '0;
		{o_prm_valid, o_prm_wd, o_cfg_valid, o_cmd_valid, o_cmd} = '0;
	end

	// bus kind and link state
	task automatic link(input logic on, input logic can, input logic rg, input logic [15:0] kb);
		@(posedge i_clock);
		o_online <= on;
		o_is_can <= can;
		o_ring   <= rg;
		o_kbaud  <= kb;
	endtask

	// parameter telegram when p is set, else configuration telegram
	task automatic frame(input logic p, input logic [15:0] wd);
		@(posedge i_clock);
		o_prm_valid <= p;
		o_cfg_valid <= !p;
		o_prm_wd    <= wd;
		@(posedge i_clock);
		o_prm_valid <= 1'b0;
		o_cfg_valid <= 1'b0;
		o_prm_wd    <= ~wd; // no stale timeout after the pulse
	endtask

	// command telegram with process data and parameter words
	task automatic send(input telegram_type t);
		@(posedge i_clock);
		o_cmd_valid <= 1'b1;
		o_cmd       <= t;
		@(posedge i_clock);
		o_cmd_valid <= 1'b0;
		o_cmd       <= ~t; // released lines carry no stale data
	endtask
endmodule

// ---- fieldbus_cyclic_data_channel_bench.sv ----
// self-checking bench of the cyclic data channel
// assumes the master model and the checker compiled beside it
`timescale 1ns/10ps
module fieldbus_cyclic_data_channel_bench
	import fieldbus_cyclic_pkg::*;
;
	// ****************************************************************
	// signals, instances and tasks
	// ****************************************************************
	localparam logic [7:0]  RA [8] = '{A_CMD_LEN, A_ACT_LEN, A_PRM_LEN, A_FORMAT,
		A_WATCHDOG, A_CYCLE, A_PROFILE, A_BUS_TEXT};
	localparam logic [31:0] RV [8] = '{32'(LEN_DEF), 32'(LEN_DEF), 32'(PRM_DEF),
		32'(FMT_DEF), 32'(WD_DEF), 32'(CYC_DEF), 32'(PROF_DEF), TXT_OFFL};
	localparam logic [7:0]  WA [4] = '{A_CMD_LEN, A_ACT_LEN, A_PRM_LEN, A_CYCLE};
	localparam logic [31:0] WV [4] = '{32'h21, 32'h3, 32'h13, 32'h1f3};
	localparam logic [31:0] EV [4] = '{32'(LEN_MAX), 32'h2, 32'(PRM_MAX), 32'(CYC_MIN)};
	logic             clock = 1'b0;
	logic             rst = 1'b1;
	logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
	logic [31:0]      wdata = 32'h0;
	logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic             arvalid = 1'b0, rready = 1'b0;
	telegram_type     act_src = '0, t = '0;
	drive_status_type drv = 3'b100;
	int               miscompares = 0, comparisons = 0;
	wire logic        awready, wready, bvalid, arready, rvalid, irq, actv, den, dhalt;
	wire logic        online, can, ring, prmv, cfgv, cmdv, cerr, aben;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [15:0] kbaud, prmwd, cw, baud;
	wire telegram_type cmdi, cmd_o, act_o;
	wire bus_state_type bst;

	always #4 clock = ~clock;

	fieldbus_master_model u_fieldbus_master_model (.i_clock(clock), .o_online(online),
		.o_is_can(can), .o_ring(ring), .o_kbaud(kbaud), .o_prm_valid(prmv),
		.o_prm_wd(prmwd), .o_cfg_valid(cfgv), .o_cmd_valid(cmdv), .o_cmd(cmdi));

	fieldbus_cyclic_data_channel u_fieldbus_cyclic_data_channel (.i_clock(clock),
		.i_sys_rst(rst), .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
		.o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(4'hf),
		.i_axi_wvalid(wvalid), .o_axi_wready(wready), .o_axi_bresp(bresp),
		.o_axi_bvalid(bvalid), .i_axi_bready(bready), .i_axi_araddr(araddr),
		.i_axi_arvalid(arvalid), .o_axi_arready(arready), .o_axi_rdata(rdata),
		.o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready), .o_irq(irq),
		.i_bus_online(online), .i_bus_is_can(can), .i_ring_bus(ring),
		.i_detected_kbaud(kbaud), .i_prm_valid(prmv), .i_prm_watchdog_ms(prmwd),
		.i_cfg_valid(cfgv), .i_cmd_valid(cmdv), .i_cmd(cmdi), .i_act_src(act_src),
		.i_drive(drv), .o_cmd(cmd_o), .o_act(act_o), .o_act_valid(actv),
		.o_control_word(cw), .o_drive_enable(den), .o_drive_halt(dhalt),
		.o_comm_error(cerr), .o_autobaud_en(aben), .o_baud_kbaud(baud), .o_bus_state(bst));

	// value compare
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// axi4-lite write
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ah, wh;
		ah = 1'b0;
		wh = 1'b0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ah && wh)) begin
			@(posedge clock);
			ah = ah | awready;
			wh = wh | wready;
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end
		do @(posedge clock); while (!bvalid);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
	endtask

	// axi4-lite read
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clock); while (!rvalid);
		rready <= 1'b0;
		chk(rdata, e);
		chk(32'(rresp), 32'(er));
	endtask

	// wait for a process tick
	task automatic tick;
		do @(posedge clock); while (actv !== 1'b1);
	endtask

	task automatic test_done;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// hang guard
	initial begin
		#1_200_000;
		miscompares++;
		test_done;
	end

	// test sequence
	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) rd(RA[i], RV[i], RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			wr(WA[i], WV[i], RESP_OKAY);
			rd(WA[i], EV[i], RESP_OKAY);
		end
		wr(8'h40, 32'h1, RESP_SLVERR);
		rd(8'h40, 32'h0, RESP_SLVERR);
		wr(A_WATCHDOG, 32'h9, RESP_OKAY);
		rd(A_WATCHDOG, 32'(WD_DEF), RESP_OKAY);
		$display("test registers done");
		u_fieldbus_master_model.link(1'b0, 1'b0, 1'b1, 16'h05dc);
		rd(A_BAUD, 32'h5dc, RESP_OKAY);
		chk(32'(irq), 32'h0);
		wr(A_IRQ_MASK, 32'h4, RESP_OKAY);
		repeat (2) @(posedge clock);
		chk(32'(irq), 32'h1);
		u_fieldbus_master_model.link(1'b0, 1'b1, 1'b0, 16'h05dc);
		wr(A_IRQ_STS, 32'h4, RESP_OKAY);
		wr(A_BAUD, 32'h7d, RESP_OKAY);
		rd(A_BAUD, 32'h7d, RESP_OKAY);
		chk(32'({irq, aben}), 32'h0);
		wr(A_BAUD, 32'h0, RESP_OKAY);
		repeat (3) @(posedge clock);
		chk(32'(aben), 32'h1);
		$display("test baud and interrupt done");
		wr(A_CMD_LEN, 32'h4, RESP_OKAY);
		wr(A_ACT_LEN, 32'h4, RESP_OKAY);
		wr(A_FORMAT, 32'h1, RESP_OKAY);
		u_fieldbus_master_model.link(1'b1, 1'b0, 1'b1, 16'h05dc);
		u_fieldbus_master_model.frame(1'b1, 16'h0007);
		rd(A_WATCHDOG, 32'h7, RESP_OKAY);
		rd(A_BUS_TEXT, TXT_WCFG, RESP_OKAY);
		u_fieldbus_master_model.frame(1'b0, 16'h0000);
		rd(A_BUS_TEXT, TXT_DXCH, RESP_OKAY);
		act_src.data[2:0] <= {16'hcccc, 16'hbbbb, 16'haaaa};
		t.data[2:0] = {16'h5678, 16'h1234, 16'h0003};
		t.param[0] = 16'hbeef;
		u_fieldbus_master_model.send(t);
		tick;
		chk(32'({cmd_o.data[1], cmd_o.data[0]}), 32'h00031234);
		chk(32'(cmd_o.data[2]), 32'h0);
		chk(32'({cw, den, dhalt}), 32'h0000f);
		chk(32'({act_o.data[1], act_o.data[0]}), 32'haaaabbbb);
		chk(32'(act_o.data[2]), 32'h0);
		wr(A_FORMAT, 32'h0, RESP_OKAY);
		wr(A_PROFILE, 32'(PROF_FREE), RESP_OKAY);
		drv <= 3'b110;
		t.data[0] = 16'ha000;
		u_fieldbus_master_model.send(t);
		tick;
		chk(32'({den, dhalt}), 32'h3);
		chk(32'(cmd_o.data[1]), 32'ha000);
		chk(32'(act_o.data[0]), 32'h0033);
		rd(A_STS_WD, 32'h33, RESP_OKAY);
		rd(A_CTRL_WD, 32'ha000, RESP_OKAY);
		u_fieldbus_master_model.link(1'b0, 1'b0, 1'b0, 16'h05dc);
		rd(A_BUS_TEXT, TXT_OFFL, RESP_OKAY);
		$display("test exchange done");
		test_done;
	end
endmodule
